// file: core/tf_inhibit_consts.vh
// Purpose: constants for the terminal flag inhibit mode command handler
// Assumes: 32-bit AXI4-Lite register words, index times four gives the byte address
// Notes: definitions only
`ifndef TF_INHIBIT_CONSTS_VH
`define TF_INHIBIT_CONSTS_VH

// register indexes
`define IDX_CFG1 6'h01
`define IDX_STATUS_BITS 6'h06
`define IDX_TF_INHIBIT 6'h13
`define IDX_IRQ_STAT 6'h20
`define IDX_IRQ_MASK 6'h21
`define IDX_MSG_STAT 6'h22

// configuration register 1 fields
`define CFG1_UMC_INVALID 0
`define CFG1_ILL_DETECT 1
`define CFG1_SOFT_RESET 2
`define CFG1_RESET 2'h0

// status bits register field
`define STB_TERMINAL_FLAG 0

// interrupt bit positions
`define IRQ_W 4
`define IRQ_WORD_AVAIL 0
`define IRQ_DESCRIPTOR_BROADCAST_FLAG_RX 1
`define IRQ_ILL_CMD 2
`define IRQ_MSG_ERR 3

// mode codes
`define MC_INHIBIT_FLAG 5'h06
`define MC_OVERRIDE_FLAG 5'h07
`define MC_RESET_TERMINAL 5'h08

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// address and data widths
`define AXI_AW 8
`define AXI_DW 32
`define IDX_LSB 2

`endif

// file: core/pin_sync3.v
// Purpose: bring an asynchronous pin level into the clk_sys domain
// Assumes: pin level held far longer than three clock cycles
// Notes: the output only moves when the second and third stages agree
`timescale 1ns/1ns
`include "tf_inhibit_consts.vh"

module pin_sync3 #(
  parameter RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // pin and its clean level
  input wire pin_in,
  output reg level_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // first stage feeds only the second; agreement filters a late settle
  always @(posedge clk_sys) begin
    if (!resetn) begin
      s1_r <= RESET_LEVEL;
      s2_r <= RESET_LEVEL;
      s3_r <= RESET_LEVEL;
      level_r <= RESET_LEVEL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule

// file: core/axil_reg_port.v
// Purpose: AXI4-Lite slave front end for a word register file
// Assumes: one write and one read outstanding at a time
// Notes: register file stays in the parent; this only speaks the protocol
`timescale 1ns/1ns
`include "tf_inhibit_consts.vh"

module axil_reg_port (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // write channels
  input wire [`AXI_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [`AXI_DW-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read channels
  input wire [`AXI_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [`AXI_DW-1:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // register file side
  output reg wr_en,
  output reg [5:0] wr_idx,
  output reg [`AXI_DW-1:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_ok,
  output wire [5:0] rd_idx,
  input wire [`AXI_DW-1:0] rd_data,
  input wire rd_ok
);

  reg aw_got_r;
  reg w_got_r;
  reg aw_got_nxt;
  reg w_got_nxt;
  reg bvalid_nxt;
  reg rvalid_nxt;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_got_nxt & w_got_nxt & ~wr_en & ~s_axi_bvalid;

  assign rd_idx = s_axi_araddr[`IDX_LSB+5:`IDX_LSB];

  // address and data may arrive in either order
  always @* begin
    aw_got_nxt = aw_got_r | aw_hs;
    w_got_nxt = w_got_r | w_hs;
    bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
    // response waits for the cycle in which the parent has decoded the index
    if (wr_en) begin
      bvalid_nxt = 1'b1;
    end
    rvalid_nxt = (s_axi_rvalid & ~s_axi_rready) | ar_hs;
  end

  // ready is registered so it never depends on valid combinationally
  always @(posedge clk_sys) begin
    if (!resetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= {`AXI_DW{1'b0}};
      wr_en <= 1'b0;
      wr_idx <= 6'h00;
      wr_data <= {`AXI_DW{1'b0}};
      wr_strb <= 4'h0;
    end else begin
      wr_en <= 1'b0;
      if (aw_hs) begin
        wr_idx <= s_axi_awaddr[`IDX_LSB+5:`IDX_LSB];
      end
      if (w_hs) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      aw_got_r <= aw_got_nxt & ~do_wr;
      w_got_r <= w_got_nxt & ~do_wr;
      s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_got_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      // wr_en follows both halves; bresp is taken from its decode
      if (do_wr) begin
        wr_en <= 1'b1;
      end
      if (wr_en) begin
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (ar_hs) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule

// file: core/tf_inhibit_handler.v
// Purpose: inhibit terminal flag mode command handling in a remote terminal
// Assumes: command fields arrive decoded, same clock, one cmd_valid pulse per message
// Notes: other mode codes only matter here for clearing the flag inhibit
// Behaviour
// - mode code 00110 with transmit bit set is the inhibit flag command
// - valid command: clear message error, send status, descriptor flags updated
// - broadcast: set broadcast received status bit, no status word sent
// - success: record bus in info word, clear its errors, offer irqs
// - executing the command sets the flag inhibit bit, index 0x0013
// - while inhibited, host terminal flag is ignored, status sent flag clear
// - override flag or reset terminal command clears the inhibit
// - soft reset bit or master reset pin also clears the inhibit
// - invalid word, or receive with undefined invalid set: total silence
// - undefined invalid case ignores the illegalization table bit
// - receive, table bit clear: in form answer, access error set
// - table bit clear or detection off gives in form answer
// - table bit set with detection on: message error, illegal command info, irqs
// - data word follows: no status, message and word count errors
`timescale 1ns/1ns
`include "tf_inhibit_consts.vh"

module tf_inhibit_handler (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // master reset pin, active low, asynchronous
  input wire master_reset_pin_n,
  // decoded command from the message decoder
  input wire cmd_valid,
  input wire cmd_word_ok,
  input wire cmd_is_mode,
  input wire cmd_tr,
  input wire [4:0] cmd_code,
  input wire cmd_descriptor_broadcast_flag,
  input wire cmd_bus,
  input wire cmd_data_follows,
  input wire illegal_table_bit,
  // status word request to the encoder
  output reg status_tx_r,
  output reg status_tf_r,
  output reg status_me_r,
  output reg status_bcr_r,
  // descriptor control word update
  output reg desc_wr_r,
  output reg descriptor_access_error_r,
  output reg descriptor_broadcast_flag_r,
  output reg descriptor_pingpong_flag_r,
  // message info word write
  output reg info_wr_r,
  output reg receiving_bus_id_r,
  output reg message_error_flag_r,
  output reg illegal_command_flag_r,
  output reg terminal_to_terminal_flag_r,
  output reg word_count_error_flag_r,
  // interrupt
  output reg irq_r,
  // AXI4-Lite register bus
  input wire [`AXI_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [`AXI_DW-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`AXI_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [`AXI_DW-1:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  wire wr_en;
  wire [5:0] wr_idx;
  wire [`AXI_DW-1:0] wr_data;
  wire [3:0] wr_strb;
  wire [5:0] rd_idx;
  reg [`AXI_DW-1:0] rd_data;
  reg rd_ok;
  reg wr_ok;
  wire mr_level;

  reg undefined_mode_invalid_r;
  reg ill_detect_r;
  reg soft_reset_bit_r;
  reg host_tf_r;
  reg tf_inhibit_r;
  reg [`IRQ_W-1:0] irq_stat_r;
  reg [`IRQ_W-1:0] irq_mask_r;
  reg [`IRQ_W-1:0] irq_stat_nxt;
  reg me_r;
  reg bcr_r;

  // decode results
  reg act;
  reg send_st;
  reg me_nxt;
  reg ae_nxt;
  reg bc_nxt;
  reg i_message_error_flag;
  reg i_ill;
  reg i_wct;
  reg set_inh;
  reg clr_inh_cmd;
  reg [`IRQ_W-1:0] ev;

  axil_reg_port u_port (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // pin idles high; low means master reset
  pin_sync3 #(
    .RESET_LEVEL(1'b1)
  ) u_mr_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in(master_reset_pin_n),
    .level_r(mr_level)
  );

  wire mr_act = ~mr_level;
  wire wr_lo = wr_en & wr_strb[0];

  // command classification; silence is the default for every path
  always @* begin
    act = 1'b0;
    send_st = 1'b0;
    me_nxt = me_r;
    ae_nxt = 1'b0;
    bc_nxt = cmd_descriptor_broadcast_flag;
    i_message_error_flag = 1'b0;
    i_ill = 1'b0;
    i_wct = 1'b0;
    set_inh = 1'b0;
    clr_inh_cmd = 1'b0;
    ev = {`IRQ_W{1'b0}};
    if (cmd_valid & cmd_word_ok & cmd_is_mode & cmd_tr & ~cmd_data_follows &
        ((cmd_code == `MC_OVERRIDE_FLAG) | (cmd_code == `MC_RESET_TERMINAL))) begin
      clr_inh_cmd = 1'b1;
    end
    // undefined-invalid check comes first, so a receive it rejects never reaches the table bit
    if (cmd_valid & cmd_word_ok & cmd_is_mode & (cmd_code == `MC_INHIBIT_FLAG) &
        ~(~cmd_tr & undefined_mode_invalid_r)) begin
      act = 1'b1;
      ev[`IRQ_WORD_AVAIL] = 1'b1;
      ev[`IRQ_DESCRIPTOR_BROADCAST_FLAG_RX] = cmd_descriptor_broadcast_flag;
      if (cmd_data_follows) begin
        me_nxt = 1'b1;
        ae_nxt = 1'b1;
        bc_nxt = 1'b0;
        i_message_error_flag = 1'b1;
        i_wct = 1'b1;
        ev[`IRQ_DESCRIPTOR_BROADCAST_FLAG_RX] = 1'b0;
        ev[`IRQ_MSG_ERR] = 1'b1;
      end else if (cmd_tr) begin
        me_nxt = 1'b0;
        send_st = ~cmd_descriptor_broadcast_flag;
        set_inh = 1'b1;
      end else if (ill_detect_r & illegal_table_bit) begin
        me_nxt = 1'b1;
        send_st = ~cmd_descriptor_broadcast_flag;
        ae_nxt = 1'b1;
        i_message_error_flag = 1'b1;
        i_ill = 1'b1;
        ev[`IRQ_ILL_CMD] = 1'b1;
      end else begin
        me_nxt = 1'b0;
        send_st = ~cmd_descriptor_broadcast_flag;
        ae_nxt = 1'b1;
      end
    end
  end

  // a new event beats a write-one-to-clear in the same cycle
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_lo && wr_idx == `IDX_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~wr_data[`IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | ev;
  end

  // write decode; the inhibit index accepts writes but keeps its state
  always @* begin
    if (wr_idx == `IDX_CFG1) begin
      wr_ok = 1'b1;
    end else if (wr_idx == `IDX_STATUS_BITS) begin
      wr_ok = 1'b1;
    end else if (wr_idx == `IDX_TF_INHIBIT) begin
      wr_ok = 1'b1;
    end else if (wr_idx == `IDX_IRQ_STAT) begin
      wr_ok = 1'b1;
    end else if (wr_idx == `IDX_IRQ_MASK) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // read decode; unmapped indexes read zero with an error answer
  always @* begin
    rd_data = {`AXI_DW{1'b0}};
    rd_ok = 1'b1;
    if (rd_idx == `IDX_CFG1) begin
      rd_data[`CFG1_UMC_INVALID] = undefined_mode_invalid_r;
      rd_data[`CFG1_ILL_DETECT] = ill_detect_r;
    end else if (rd_idx == `IDX_STATUS_BITS) begin
      rd_data[`STB_TERMINAL_FLAG] = host_tf_r;
    end else if (rd_idx == `IDX_TF_INHIBIT) begin
      rd_data[0] = tf_inhibit_r;
    end else if (rd_idx == `IDX_IRQ_STAT) begin
      rd_data[`IRQ_W-1:0] = irq_stat_r;
    end else if (rd_idx == `IDX_IRQ_MASK) begin
      rd_data[`IRQ_W-1:0] = irq_mask_r;
    end else if (rd_idx == `IDX_MSG_STAT) begin
      rd_data[2:0] = {descriptor_pingpong_flag_r, bcr_r, me_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // host registers; soft reset bit is a one-cycle self-clearing request
  always @(posedge clk_sys) begin
    if (!resetn) begin
      undefined_mode_invalid_r <= 1'b0;
      ill_detect_r <= 1'b0;
      soft_reset_bit_r <= 1'b0;
      host_tf_r <= 1'b0;
      irq_mask_r <= {`IRQ_W{1'b0}};
      irq_stat_r <= {`IRQ_W{1'b0}};
      irq_r <= 1'b0;
    end else begin
      soft_reset_bit_r <= 1'b0;
      if (wr_lo && wr_idx == `IDX_CFG1) begin
        undefined_mode_invalid_r <= wr_data[`CFG1_UMC_INVALID];
        ill_detect_r <= wr_data[`CFG1_ILL_DETECT];
        soft_reset_bit_r <= wr_data[`CFG1_SOFT_RESET];
      end else if (wr_lo && wr_idx == `IDX_STATUS_BITS) begin
        host_tf_r <= wr_data[`STB_TERMINAL_FLAG];
      end else if (wr_lo && wr_idx == `IDX_IRQ_MASK) begin
        irq_mask_r <= wr_data[`IRQ_W-1:0];
      end
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // inhibit: any reset source wins over a command setting it the same cycle
  always @(posedge clk_sys) begin
    if (!resetn) begin
      tf_inhibit_r <= 1'b0;
    end else if (soft_reset_bit_r | mr_act | clr_inh_cmd) begin
      tf_inhibit_r <= 1'b0;
    end else if (set_inh) begin
      tf_inhibit_r <= 1'b1;
    end
  end

  // message status bits and the outgoing words
  always @(posedge clk_sys) begin
    if (!resetn) begin
      me_r <= 1'b0;
      bcr_r <= 1'b0;
      status_tx_r <= 1'b0;
      status_tf_r <= 1'b0;
      status_me_r <= 1'b0;
      status_bcr_r <= 1'b0;
      desc_wr_r <= 1'b0;
      descriptor_access_error_r <= 1'b0;
      descriptor_broadcast_flag_r <= 1'b0;
      descriptor_pingpong_flag_r <= 1'b0;
      info_wr_r <= 1'b0;
      receiving_bus_id_r <= 1'b0;
      message_error_flag_r <= 1'b0;
      illegal_command_flag_r <= 1'b0;
      terminal_to_terminal_flag_r <= 1'b0;
      word_count_error_flag_r <= 1'b0;
    end else begin
      status_tx_r <= send_st;
      desc_wr_r <= act;
      info_wr_r <= act;
      if (soft_reset_bit_r | mr_act) begin
        me_r <= 1'b0;
        bcr_r <= 1'b0;
      end else if (act) begin
        me_r <= me_nxt;
        bcr_r <= cmd_descriptor_broadcast_flag & ~cmd_data_follows;
      end
      if (send_st) begin
        // flag is masked whenever the inhibit is already set or is being set by this command
        status_tf_r <= host_tf_r & ~(tf_inhibit_r | set_inh);
        status_me_r <= me_nxt;
        status_bcr_r <= 1'b0;
      end
      if (act) begin
        descriptor_access_error_r <= ae_nxt;
        descriptor_broadcast_flag_r <= bc_nxt;
        descriptor_pingpong_flag_r <= ~descriptor_pingpong_flag_r;
        receiving_bus_id_r <= cmd_bus;
        message_error_flag_r <= i_message_error_flag;
        illegal_command_flag_r <= i_ill;
        terminal_to_terminal_flag_r <= 1'b0;
        word_count_error_flag_r <= i_wct;
      end
    end
  end

endmodule

// file: test/tf_inhibit_properties.sv
// Purpose: port level checks on the flag inhibit handler
// Assumes: config and host flag are only seen through commands and bus writes
// Notes: shadow inhibit is cleared on any config write, so it may under-check
`timescale 1ns/1ns
`include "tf_inhibit_consts.vh"
module tf_inhibit_checker (
  // clock, reset, pin
  input wire clk_sys, resetn, master_reset_pin_n,
  // decoded command
  input wire cmd_valid, cmd_word_ok, cmd_is_mode, cmd_tr,
  input wire [4:0] cmd_code,
  input wire cmd_descriptor_broadcast_flag, cmd_bus, cmd_data_follows, illegal_table_bit,
  // status, descriptor and info outputs
  input wire status_tx_r, status_tf_r, status_me_r, desc_wr_r,
  input wire descriptor_access_error_r, descriptor_broadcast_flag_r,
  input wire descriptor_pingpong_flag_r, info_wr_r, receiving_bus_id_r,
  input wire message_error_flag_r, illegal_command_flag_r,
  input wire terminal_to_terminal_flag_r, word_count_error_flag_r,
  // write address channel
  input wire [`AXI_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid, s_axi_awready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // command classes
  wire mc = cmd_valid && cmd_word_ok && cmd_is_mode;
  wire mc6 = mc && cmd_code == `MC_INHIBIT_FLAG;
  wire ok6 = mc6 && cmd_tr && !cmd_data_follows;
  wire rx6 = mc6 && !cmd_tr && !cmd_data_follows;
  wire clr = mc && cmd_tr && !cmd_data_follows &&
    (cmd_code == `MC_OVERRIDE_FLAG || cmd_code == `MC_RESET_TERMINAL);
  wire cfg_wr = s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == `IDX_CFG1;
  reg inh_r;
  // shadow of the inhibit; clears early rather than late to avoid false alarms
  always @(posedge clk_sys) begin
    if (!resetn || !master_reset_pin_n || clr || cfg_wr)
      inh_r <= 1'b0;
    else if (ok6)
      inh_r <= 1'b1;
  end
  AST_OK_STATUS: assert property (ok6 && !cmd_descriptor_broadcast_flag |=> status_tx_r && !status_me_r)
    else $error("inhibit command status word wrong");
  AST_DESCRIPTOR_BROADCAST_FLAG_QUIET: assert property (ok6 && cmd_descriptor_broadcast_flag |=> !status_tx_r && desc_wr_r)
    else $error("broadcast inhibit command answered");
  AST_OK_INFO: assert property (ok6 |=> info_wr_r && receiving_bus_id_r == $past(cmd_bus)
    && !message_error_flag_r && !illegal_command_flag_r && !terminal_to_terminal_flag_r
    && !word_count_error_flag_r) else $error("info word after inhibit command wrong");
  AST_OK_DESC: assert property (ok6 |=> desc_wr_r && !descriptor_access_error_r
    && descriptor_broadcast_flag_r == $past(cmd_descriptor_broadcast_flag)
    && descriptor_pingpong_flag_r != $past(descriptor_pingpong_flag_r))
    else $error("descriptor after inhibit command wrong");
  AST_BAD_WORD: assert property (cmd_valid && !cmd_word_ok |=> !status_tx_r && !desc_wr_r
    && !info_wr_r) else $error("invalid word produced output");
  AST_DATA_WORD: assert property (mc6 && cmd_tr && cmd_data_follows |=> !status_tx_r
    && desc_wr_r && descriptor_access_error_r && !descriptor_broadcast_flag_r && info_wr_r
    && message_error_flag_r && word_count_error_flag_r) else $error("data word case wrong");
  AST_IN_FORM: assert property (rx6 && !illegal_table_bit |=> !info_wr_r ||
    (descriptor_access_error_r && !message_error_flag_r && !illegal_command_flag_r))
    else $error("in form answer wrong");
  AST_ILLEGAL: assert property (rx6 && illegal_table_bit |=> !info_wr_r ||
    (descriptor_access_error_r && illegal_command_flag_r == message_error_flag_r))
    else $error("illegal answer wrong");
  AST_TF_MASKED: assert property (status_tx_r && inh_r |-> !status_tf_r)
    else $error("terminal flag sent while inhibited");
  COV_DESCRIPTOR_BROADCAST_FLAG: cover property (ok6 && cmd_descriptor_broadcast_flag);
  COV_DATA: cover property (mc6 && cmd_data_follows);
  COV_MASKED: cover property (status_tx_r && inh_r);
endmodule
bind tf_inhibit_handler tf_inhibit_checker chk (.*);

// file: test/mode_cmd_source.sv
// Purpose: bus controller stand-in issuing decoded mode commands
// Assumes: one message per call, optional idle gap before it
// Notes: fields flip after the valid cycle so late sampling shows up
`timescale 1ns/1ns
module mode_cmd_source (
  // clock
  input wire clk_sys,
  // decoded command toward the handler
  output logic cmd_valid, cmd_word_ok, cmd_is_mode, cmd_tr,
  output logic [4:0] cmd_code,
  output logic cmd_descriptor_broadcast_flag, cmd_bus, cmd_data_follows, illegal_table_bit
);
  // idle state at time zero
  initial begin
    cmd_valid = 1'b0;
    {cmd_word_ok, cmd_is_mode, cmd_tr, cmd_code} = 8'h00;
    {cmd_descriptor_broadcast_flag, cmd_bus, cmd_data_follows, illegal_table_bit} = 4'h0;
  end
  // f is {word_ok, tr, descriptor_broadcast_flag, bus, data_follows, table_bit}
  task automatic issue(input logic [4:0] code, input logic [5:0] f, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_is_mode <= 1'b1;
    cmd_code <= code;
    {cmd_word_ok, cmd_tr, cmd_descriptor_broadcast_flag, cmd_bus, cmd_data_follows, illegal_table_bit} <= f;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_is_mode <= 1'b0;
    cmd_code <= ~code;
    {cmd_word_ok, cmd_tr, cmd_descriptor_broadcast_flag, cmd_bus, cmd_data_follows, illegal_table_bit} <= ~f;
  endtask
endmodule

// file: test/inhibit_terminal_flag_mode_handler_tb.sv
// Purpose: self-checking bench for the flag inhibit handler
// Assumes: config 1 reads back, inhibit register read-only
// Notes: table rows first, then inhibit set and clear paths by hand
`timescale 1ns/1ns
`include "tf_inhibit_consts.vh"
module inhibit_terminal_flag_mode_handler_tb;
  logic clk_sys, resetn, master_reset_pin_n;
  logic cmd_valid, cmd_word_ok, cmd_is_mode, cmd_tr, cmd_descriptor_broadcast_flag, cmd_bus, cmd_data_follows;
  logic illegal_table_bit, status_tx_r, status_tf_r, status_me_r, status_bcr_r, desc_wr_r;
  logic [4:0] cmd_code;
  logic descriptor_access_error_r, descriptor_broadcast_flag_r, descriptor_pingpong_flag_r;
  logic info_wr_r, receiving_bus_id_r, message_error_flag_r, illegal_command_flag_r;
  logic terminal_to_terminal_flag_r, word_count_error_flag_r, irq_r;
  logic [`AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [`AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pp, aw, w;
  logic [5:0] f;
  logic [8:0] e;
  int err_count, cmp_count, cyc;
  localparam logic [7:0] A_CFG = {`IDX_CFG1, 2'b00};
  localparam logic [7:0] A_STB = {`IDX_STATUS_BITS, 2'b00};
  localparam logic [7:0] A_INH = {`IDX_TF_INHIBIT, 2'b00};
  localparam logic [7:0] A_IST = {`IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_IMS = {`IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_MSG = {`IDX_MSG_STAT, 2'b00};
  // {word_ok, tr, descriptor_broadcast_flag, bus, data_follows, table_bit} then {tx, me, desc_wr,
  // access_err, descriptor_broadcast_flag_flag, info_wr, msg_err, ill_cmd, wc_err}
  localparam logic [14:0] ROWS [7] = '{
    {6'b110000, 9'b101001000},
    {6'b111100, 9'b001011000},
    {6'b100000, 9'b101101000},
    {6'b100101, 9'b111101110},
    {6'b101001, 9'b001111110},
    {6'b110110, 9'b001101101},
    {6'b010000, 9'b000000000}};
  tf_inhibit_handler uut (.*);
  mode_cmd_source bc (.*);
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // each channel held until its own handshake; bready up from the start
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    {aw, w} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // hang guard, a few thousand cycles is ample
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    master_reset_pin_n = 1'b1;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rdc(A_CFG, 32'h0, `RESP_OKAY);
    rdc(A_INH, 32'h0, `RESP_OKAY);
    wr(A_CFG, 32'h2, `RESP_OKAY);
    wr(A_IMS, 32'hF, `RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      {f, e} = ROWS[i];
      pp = descriptor_pingpong_flag_r;
      bc.issue(`MC_INHIBIT_FLAG, f, i);
      @(negedge clk_sys);
      chk({status_tx_r, desc_wr_r, info_wr_r}, {e[8], e[6], e[3]});
      if (e[8]) chk(status_me_r, e[7]);
      if (e[8]) chk(status_bcr_r, 1'b0);
      if (e[6]) chk({descriptor_access_error_r, descriptor_broadcast_flag_r,
        descriptor_pingpong_flag_r}, {e[5:4], ~pp});
      if (e[3]) chk({receiving_bus_id_r, message_error_flag_r, illegal_command_flag_r,
        terminal_to_terminal_flag_r, word_count_error_flag_r}, {f[2], e[2:1], 1'b0, e[0]});
    end
    chk(irq_r, 1'b1);
    rdc(A_MSG, 32'h1, `RESP_OKAY);
    rdc(A_IST, 32'hF, `RESP_OKAY);
    wr(A_INH, 32'h0, `RESP_OKAY);
    rdc(A_INH, 32'h1, `RESP_OKAY);
    wr(A_IST, 32'hF, `RESP_OKAY);
    rdc(A_IST, 32'h0, `RESP_OKAY);
    chk(irq_r, 1'b0);
    wr(8'hFC, 32'h1, `RESP_SLVERR);
    rdc(8'hFC, 32'h0, `RESP_SLVERR);
    // host flag visible only until the inhibit command lands
    bc.issue(`MC_OVERRIDE_FLAG, 6'b110000, 0);
    wr(A_STB, 32'h1, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      bc.issue(`MC_INHIBIT_FLAG, i == 1 ? 6'b110000 : 6'b100000, 1);
      @(negedge clk_sys);
      chk({status_tx_r, status_tf_r}, {1'b1, i == 0});
    end
    // every way of lifting the inhibit, each after setting it again
    for (int m = 0; m < 4; m++) begin
      bc.issue(`MC_INHIBIT_FLAG, 6'b110000, 0);
      rdc(A_INH, 32'h1, `RESP_OKAY);
      case (m)
        0: bc.issue(`MC_OVERRIDE_FLAG, 6'b110000, 0);
        1: bc.issue(`MC_RESET_TERMINAL, 6'b111000, 0);
        2: wr(A_CFG, 32'h6, `RESP_OKAY);
        default: begin
          master_reset_pin_n <= 1'b0;
          repeat (8) @(posedge clk_sys);
          master_reset_pin_n <= 1'b1;
          repeat (8) @(posedge clk_sys);
        end
      endcase
      rdc(A_INH, 32'h0, `RESP_OKAY);
    end
    // masked event still latches status but keeps the line low
    wr(A_IMS, 32'h0, `RESP_OKAY);
    bc.issue(`MC_INHIBIT_FLAG, 6'b111000, 0);
    rdc(A_IST, 32'h3, `RESP_OKAY);
    chk(irq_r, 1'b0);
    rdc(A_MSG, 32'h2, `RESP_OKAY);
    // detection off: a table bit alone still gets the in form answer
    wr(A_CFG, 32'h0, `RESP_OKAY);
    bc.issue(`MC_INHIBIT_FLAG, 6'b100001, 0);
    @(negedge clk_sys);
    chk({status_tx_r, status_me_r, descriptor_access_error_r, illegal_command_flag_r}, 4'hA);
    wr(A_CFG, 32'h3, `RESP_OKAY);
    bc.issue(`MC_INHIBIT_FLAG, 6'b100101, 2);
    @(negedge clk_sys);
    chk({status_tx_r, desc_wr_r, info_wr_r}, 3'b000);
    stop_test;
  end
endmodule
